// >>> ferro_spi_access.sv
// Serial slave access, status and write protection logic for a 32K x 8 memory
//
// Behaviour
// RULE1: Status byte: enable bit 7, guard bits 3..2, latch flag bit 1, others zero.
// RULE2: Status write data never loads the latch flag.
// RULE3: Set command sets latch; write frame end or clear command clears it.
// RULE4: Guard bits survive reset as nonvolatile state.
// RULE5: Guard 00 none, 01 from 6000h, 10 from 4000h, 11 everything.
// RULE6: Memory byte written only with latch set and address unguarded.
// RULE7: Protect pin ignored while protect-pin enable is zero.
// RULE8: Status write refused with enable set and pin low, or latch clear.
// RULE9: Write op-code then two address bytes; low 15 bits start address.
// RULE10: Address increments per byte, wrapping 7FFFh to 0000h.
// RULE11: Each write byte committed at its eighth bit, no page limit.
// RULE12: Select rising ends any read or write.
// RULE13: Protect pin sampled only at select falling.
// RULE14: Read ignores serial input after address; one bit out per clock.
// RULE15: Data bytes travel most significant bit first.
// RULE16: Pause freezes the operation; resume continues it.
// RULE17: Master changes pause only while serial clock is low.
// RULE18: Op-codes 06, 04, 05, 01, 03, 02 with their payloads.
// RULE19: Input taken on rising clock, output on falling, modes 0 and 3.
// RULE20: One op-code per select, first byte after select falls.
// RULE21: Latch flag clear after power-on reset.
// RULE22: Serial output released while deselected or paused.
// RULE23: Status write loads enable and guard bits, then clears latch.
`timescale 1ns/1ps
`default_nettype none
module ferro_spi_access (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic [ferro_spi_pkg::DATA_W-1:0] mem_rdata,
    output logic so,
    output logic so_oe_n,
    output logic mem_we,
    output logic [ferro_spi_pkg::ADDR_W-1:0] mem_waddr,
    output logic [ferro_spi_pkg::DATA_W-1:0] mem_wdata,
    output logic [ferro_spi_pkg::ADDR_W-1:0] mem_raddr
);
    import ferro_spi_pkg::*;

    // ------------------------------------------------------------
    // Link domain, rising edge of the serial clock
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bitcnt;
        phase_t ph;
        logic [7:0] op;
        logic [7:0] sh;
        logic [ADDR_W-1:0] addr;
        logic load;
        logic rd;
        logic ev_tog;
        ev_t ev_kind;
        logic [7:0] ev_data;
        logic [ADDR_W-1:0] ev_addr;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
    } link_t;

    typedef struct packed {
        logic [7:0] out;
        logic oe_n;
    } drive_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic wp_s1;
        logic wp_s2;
        logic wp_lat;
        logic tg_s1;
        logic tg_s2;
        logic tg_d;
        logic wlf;
        logic ppe;
        logic [1:0] guard;
        logic wframe;
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wdata;
    } ctrl_t;

    link_t lk = '0;
    link_t next_lk;
    drive_t dr = '{out: 8'h00, oe_n: 1'b1};
    drive_t next_dr;
    ctrl_t c = '0;
    ctrl_t next_c;
    logic fresh = 1'b1;
    logic last;
    logic post;
    ev_t kind;
    logic [7:0] byte_in;
    logic [7:0] status_word;
    logic ev_seen;
    logic cs_rise;
    logic cs_fall;

    // Frame start marker, set while deselected
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh <= 1'b1;
        end else if (hold_n) begin
            fresh <= 1'b0;
        end
    end

    // Shift, decode and event posting
    always_comb begin
        next_lk = lk;
        if (fresh) begin
            next_lk.bitcnt = 3'h0;
            next_lk.ph = PH_OPC;
            next_lk.load = 1'b0;
            next_lk.rd = 1'b0;
        end
        next_lk.st_s1 = status_word;
        next_lk.st_s2 = lk.st_s1;
        byte_in = {next_lk.sh[6:0], si}; // RULE15
        last = (next_lk.bitcnt == BIT_LAST);
        post = 1'b0;
        kind = EV_NONE;
        if (hold_n) begin // RULE16
            next_lk.sh = byte_in; // RULE19
            next_lk.bitcnt = next_lk.bitcnt + 3'h1;
            next_lk.load = 1'b0;
            if (last) begin
                case (next_lk.ph)
                    PH_OPC: begin // RULE20
                        next_lk.op = byte_in;
                        next_lk.ph = PH_IDLE;
                        case (byte_in) // RULE18
                            OP_SET_LATCH: begin
                                post = 1'b1;
                                kind = EV_SET;
                            end
                            OP_CLEAR_LATCH: begin
                                post = 1'b1;
                                kind = EV_CLR;
                            end
                            OP_STATUS_READ: begin
                                next_lk.ph = PH_STAT;
                                next_lk.load = 1'b1;
                                next_lk.rd = 1'b1;
                            end
                            OP_STATUS_WRITE: begin
                                next_lk.ph = PH_STAT;
                                post = 1'b1;
                                kind = EV_WFRAME;
                            end
                            OP_MEM_READ: next_lk.ph = PH_ADH;
                            OP_MEM_WRITE: begin
                                next_lk.ph = PH_ADH;
                                post = 1'b1;
                                kind = EV_WFRAME;
                            end
                            default: next_lk.ph = PH_IDLE;
                        endcase
                    end
                    PH_ADH: begin
                        next_lk.addr[ADDR_W-1:8] = byte_in[6:0]; // RULE9
                        next_lk.ph = PH_ADL;
                    end
                    PH_ADL: begin
                        next_lk.addr[7:0] = byte_in;
                        next_lk.ph = PH_DATA;
                        next_lk.load = (next_lk.op == OP_MEM_READ);
                        next_lk.rd = next_lk.load;
                    end
                    PH_DATA: begin
                        if (next_lk.op == OP_MEM_WRITE) begin // RULE11
                            post = 1'b1;
                            kind = EV_MBYTE;
                        end
                        next_lk.load = (next_lk.op == OP_MEM_READ); // RULE14
                        next_lk.addr = next_lk.addr + ADDR_STEP; // RULE10
                    end
                    PH_STAT: begin
                        if (next_lk.op == OP_STATUS_WRITE) begin
                            post = 1'b1;
                            kind = EV_SDATA;
                        end
                        next_lk.ph = PH_IDLE;
                    end
                    default: next_lk.ph = PH_IDLE;
                endcase
            end
        end
        if (post) begin
            next_lk.ev_tog = ~lk.ev_tog;
            next_lk.ev_kind = kind;
            next_lk.ev_data = byte_in;
            next_lk.ev_addr = lk.addr;
        end
    end

    always_ff @(posedge sck) begin
        lk <= next_lk;
    end

    // ------------------------------------------------------------
    // Link domain, falling edge: serial output
    // ------------------------------------------------------------
    always_comb begin
        next_dr = dr;
        if (!fresh && hold_n) begin
            if (lk.load) begin
                next_dr.out = (lk.op == OP_STATUS_READ) ? lk.st_s2 : mem_rdata;
            end else begin
                next_dr.out = {dr.out[6:0], 1'b0}; // RULE15
            end
        end
        next_dr.oe_n = ~(lk.rd & hold_n & ~fresh); // RULE22
    end

    // Deselect releases the output at once
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            dr <= '{out: 8'h00, oe_n: 1'b1}; // RULE12
        end else begin
            dr <= next_dr; // RULE19
        end
    end

    assign so = dr.out[7];
    assign so_oe_n = dr.oe_n;
    assign mem_raddr = lk.addr;

    // ------------------------------------------------------------
    // System domain: status, protection and array writes
    // ------------------------------------------------------------
    assign status_word = status_byte(c.ppe, c.guard, c.wlf); // RULE1
    assign ev_seen = c.tg_s2 ^ c.tg_d;
    assign cs_rise = c.cs_s2 & ~c.cs_d;
    assign cs_fall = c.cs_d & ~c.cs_s2;

    always_comb begin
        next_c = c;
        next_c.cs_s1 = cs_n;
        next_c.cs_s2 = c.cs_s1;
        next_c.cs_d = c.cs_s2;
        next_c.wp_s1 = wp_n;
        next_c.wp_s2 = c.wp_s1;
        next_c.tg_s1 = lk.ev_tog;
        next_c.tg_s2 = c.tg_s1;
        next_c.tg_d = c.tg_s2;
        next_c.we = 1'b0;
        if (cs_fall) begin
            next_c.wp_lat = c.wp_s2; // RULE13
            next_c.wframe = 1'b0;
        end
        if (cs_rise && c.wframe) begin
            next_c.wlf = 1'b0; // RULE3
        end
        if (ev_seen) begin
            case (lk.ev_kind)
                EV_SET: next_c.wlf = 1'b1; // RULE3
                EV_CLR: next_c.wlf = 1'b0;
                EV_WFRAME: next_c.wframe = 1'b1;
                EV_SDATA: begin
                    if (c.wlf && !(c.ppe && !c.wp_lat)) begin // RULE7 RULE8
                        next_c.ppe = lk.ev_data[ST_PPE_BIT]; // RULE2 RULE23
                        next_c.guard = {lk.ev_data[ST_BGH_BIT], lk.ev_data[ST_BGL_BIT]};
                    end
                    next_c.wlf = 1'b0; // RULE23
                end
                EV_MBYTE: begin
                    next_c.we = c.wlf && !guarded(lk.ev_addr, c.guard); // RULE5 RULE6
                    next_c.waddr = lk.ev_addr;
                    next_c.wdata = lk.ev_data;
                end
                default: next_c.wframe = c.wframe;
            endcase
        end
        if (reset) begin
            next_c.wlf = WLF_RESET; // RULE21
            next_c.wframe = 1'b0;
            next_c.we = 1'b0;
            next_c.cs_d = c.cs_s2;
            next_c.tg_d = c.tg_s2;
            next_c.wp_lat = 1'b1;
            next_c.guard = c.guard; // RULE4
        end
    end

    always_ff @(posedge clk) begin
        c <= next_c;
    end

    assign mem_we = c.we;
    assign mem_waddr = c.waddr;
    assign mem_wdata = c.wdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_set_event;
        ev_seen && lk.ev_kind == EV_SET;
    endsequence

    sequence seq_write_end;
        cs_rise && c.wframe && !(ev_seen && lk.ev_kind == EV_SET);
    endsequence

    chk_latch_set: assert property (@(posedge clk) disable iff (reset)
        seq_set_event |=> c.wlf) else $error("latch not set by command"); // RULE3
    chk_latch_clear: assert property (@(posedge clk) disable iff (reset)
        seq_write_end |=> !c.wlf) else $error("latch kept after write frame"); // RULE3
    chk_write_gate: assert property (@(posedge clk) disable iff (reset)
        c.we |-> $past(c.wlf) && !guarded(c.waddr, $past(c.guard)))
        else $error("array write while disabled"); // RULE6
    chk_guard_block: assert property (@(posedge clk) disable iff (reset)
        ev_seen && lk.ev_kind == EV_MBYTE && c.wlf && !guarded(lk.ev_addr, c.guard)
        |=> c.we && c.waddr == $past(lk.ev_addr))
        else $error("permitted byte not committed"); // RULE11
    chk_status_lock: assert property (@(posedge clk) disable iff (reset)
        ev_seen && lk.ev_kind == EV_SDATA && c.ppe && !c.wp_lat
        |=> $stable(c.guard) && c.ppe) else $error("locked status changed"); // RULE8
    chk_pin_sample: assert property (@(posedge clk) disable iff (reset)
        !cs_fall |=> $stable(c.wp_lat)) else $error("protect pin sampled mid frame"); // RULE13
    chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        ev_seen && lk.ev_kind == EV_SDATA ##1 1'b1 |-> status_word[6:4] == 3'h0
        && !status_word[0]) else $error("reserved status bit set"); // RULE1
    chk_addr_wrap: assert property (@(posedge sck) disable iff (cs_n)
        !fresh && hold_n && lk.ph == PH_DATA && lk.bitcnt == BIT_LAST
        |=> lk.addr == $past(lk.addr) + ADDR_STEP) else $error("address step wrong"); // RULE10
    chk_pause_freeze: assert property (@(posedge sck) disable iff (cs_n)
        !fresh && !hold_n |=> $stable(lk.bitcnt) && $stable(lk.sh))
        else $error("state moved while paused"); // RULE16
    chk_output_idle: assert property (@(posedge clk) disable iff (reset)
        cs_n |-> so_oe_n) else $error("output driven while deselected"); // RULE22
endmodule : ferro_spi_access
`default_nettype wire

// >>> ferro_spi_pkg.sv
// Constants, types and decode helpers for the serial ferroelectric memory access block
package ferro_spi_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // Op-codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;

    // ------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------
    localparam int ST_PPE_BIT = 7;
    localparam int ST_BGH_BIT = 3;
    localparam int ST_BGL_BIT = 2;
    localparam int ST_WLF_BIT = 1;
    localparam logic WLF_RESET = 1'h0;
    localparam logic PPE_RESET = 1'h0;
    localparam logic [1:0] GUARD_RESET = 2'h0;

    // ------------------------------------------------------------
    // Address space and guarded ranges
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam logic [ADDR_W-1:0] GUARD_QTR_BASE = 15'h6000;
    localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 15'h4000;
    localparam logic [1:0] GUARD_NONE = 2'h0;
    localparam logic [1:0] GUARD_QTR = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_ALL = 2'h3;

    // Link phase, Gray coded along the usual path
    typedef enum logic [2:0] {
        PH_OPC = 3'h0,
        PH_ADH = 3'h1,
        PH_ADL = 3'h3,
        PH_DATA = 3'h2,
        PH_STAT = 3'h6,
        PH_IDLE = 3'h7
    } phase_t;

    // Events handed from the link domain to the system domain
    typedef enum logic [2:0] {
        EV_NONE = 3'h0,
        EV_SET = 3'h1,
        EV_CLR = 3'h2,
        EV_WFRAME = 3'h3,
        EV_SDATA = 3'h4,
        EV_MBYTE = 3'h5
    } ev_t;

    // Address lies in the range selected by the guard bits
    function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [1:0] g);
        case (g)
            GUARD_QTR: guarded = (a >= GUARD_QTR_BASE);
            GUARD_HALF: guarded = (a >= GUARD_HALF_BASE);
            GUARD_ALL: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    endfunction : guarded

    // Assemble the status byte, unused bits zero
    function automatic logic [7:0] status_byte(input logic ppe, input logic [1:0] g,
                                               input logic wlf);
        status_byte = 8'h00;
        status_byte[ST_PPE_BIT] = ppe;
        status_byte[ST_BGH_BIT] = g[1];
        status_byte[ST_BGL_BIT] = g[0];
        status_byte[ST_WLF_BIT] = wlf;
    endfunction : status_byte
endpackage : ferro_spi_pkg

// >>> spi_host_model.sv
// Host controller model: mode 0 serial master with pause control
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    localparam time HALF = 80ns;
    logic oe_seen;

    // Idle levels: deselected, clock low between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        oe_seen = 1'b0;
    end

    // Select the device; clock stays low until the first bit
    task automatic open_frame();
        cs_n <= 1'b0;
        #HALF;
    endtask : open_frame

    // Deselect and keep the gap the block needs
    task automatic close_frame();
        #HALF;
        cs_n <= 1'b1;
        si <= ~si;
        #400ns;
    endtask : close_frame

    // One byte MSB first; pause after bit hold_at when below 8
    task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            #HALF;
            rx[i] = so_oe_n ? 1'bx : so;
            sck <= 1'b1;
            #HALF;
            sck <= 1'b0;
            if (7 - i == hold_at) begin
                #20ns;
                hold_n <= 1'b0;
                si <= ~si;
                // Clock keeps running during the pause and must be ignored
                repeat (2) begin
                    #HALF sck <= 1'b1;
                    #HALF sck <= 1'b0;
                end
                #20ns;
                oe_seen = so_oe_n;
                hold_n <= 1'b1;
                #20ns;
            end
        end
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> spi_ferro_memory_access_protect_tb.sv
// Self-checking bench for the serial memory access and protection block
`timescale 1ns/1ps
`default_nettype none
module spi_ferro_memory_access_protect_tb;
    import ferro_spi_pkg::*;
    logic clk;
    logic reset;
    logic wp_n;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe_n;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [ADDR_W-1:0] mem_raddr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] mem [0:32767];
    logic [7:0] rbuf [0:3];
    int errors;
    int comparisons;

    // ------------------------------------------------------------
    // Clock, array model, instances
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25ns clk = ~clk;
    end

    // Array written by the commit pulse, read asynchronously
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
    assign mem_rdata = mem[mem_raddr];

    spi_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
                           .so_oe_n(so_oe_n));
    ferro_spi_access i_dut (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
                            .wp_n(wp_n), .hold_n(hold_n), .mem_rdata(mem_rdata), .so(so),
                            .so_oe_n(so_oe_n), .mem_we(mem_we), .mem_waddr(mem_waddr),
                            .mem_wdata(mem_wdata), .mem_raddr(mem_raddr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        i_host.open_frame();
        i_host.xfer(op, 8, rx);
        i_host.close_frame();
    endtask : cmd

    task automatic expect_status(input string what, input logic [7:0] exp);
        logic [7:0] st;
        i_host.open_frame();
        i_host.xfer(OP_STATUS_READ, 8, st);
        i_host.xfer(8'h00, 8, st);
        i_host.close_frame();
        check(what, exp, st);
    endtask : expect_status

    task automatic wr_status(input logic latch, input logic [7:0] v);
        logic [7:0] rx;
        if (latch) begin
            cmd(OP_SET_LATCH);
        end
        i_host.open_frame();
        i_host.xfer(OP_STATUS_WRITE, 8, rx);
        i_host.xfer(v, 8, rx);
        i_host.close_frame();
    endtask : wr_status

    // Memory frame with n data bytes; read bytes land in rbuf
    task automatic mem_frame(input logic [7:0] op, input logic [15:0] a, input int n,
                             input logic [7:0] base, input int hold_at);
        logic [7:0] rx;
        i_host.open_frame();
        i_host.xfer(op, 8, rx);
        i_host.xfer(a[15:8], 8, rx);
        i_host.xfer(a[7:0], 8, rx);
        for (int k = 0; k < n; k++) begin
            i_host.xfer(base + 8'(k), (k == 0) ? hold_at : 8, rbuf[k]);
        end
        i_host.close_frame();
    endtask : mem_frame

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_latch();
        expect_status("status after power-on", 8'h00);
        wr_status(1'b0, 8'h8C);
        expect_status("status write without latch", 8'h00);
        cmd(OP_SET_LATCH);
        expect_status("latch after set", 8'h02);
        cmd(OP_CLEAR_LATCH);
        expect_status("latch after clear", 8'h00);
        mem_frame(OP_MEM_WRITE, 16'h0010, 1, 8'h77, 8);
        check("write without latch", 8'h00, mem[15'h0010]);
        cmd(OP_SET_LATCH);
        wr_status(1'b0, 8'hFF);
        expect_status("status fields", 8'h8C);
        wr_status(1'b1, 8'h00);
        $display("test latch done");
    endtask : t_latch

    task automatic t_guard();
        logic [14:0] a;
        logic [7:0] e;
        for (int g = 0; g < 4; g++) begin
            wr_status(1'b1, {4'h0, 2'(g), 2'h0});
            expect_status("guard bits", {4'h0, 2'(g), 2'h0});
            for (int s = 0; s < 2; s++) begin
                a = (s == 0) ? 15'h3FFF : 15'h5FFF;
                mem[a] = 8'h00;
                mem[a + 15'h0001] = 8'h00;
                cmd(OP_SET_LATCH);
                mem_frame(OP_MEM_WRITE, {1'b1, a}, 2, 8'h10 * 8'(g + 1), 8);
                for (int k = 0; k < 2; k++) begin
                    e = 8'h10 * 8'(g + 1) + 8'(k);
                    if (g == 3 || (g == 2 && a + 15'(k) >= 15'h4000)
                        || (g == 1 && a + 15'(k) >= 15'h6000)) begin
                        e = 8'h00;
                    end
                    check("guarded write", e, mem[a + 15'(k)]);
                end
            end
        end
        wr_status(1'b1, 8'h00);
        $display("test guard done");
    endtask : t_guard

    task automatic t_wrap();
        cmd(OP_SET_LATCH);
        mem_frame(OP_MEM_WRITE, 16'h7FFF, 3, 8'hC0, 8);
        check("write after wrap", 8'hC1, mem[15'h0000]);
        mem_frame(OP_MEM_READ, 16'h7FFF, 3, 8'h5A, 8);
        for (int k = 0; k < 3; k++) begin
            check("sequential read", 8'hC0 + 8'(k), rbuf[k]);
        end
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_pin();
        wr_status(1'b1, 8'h80);
        expect_status("enable with pin high", 8'h80);
        @(posedge clk) wp_n <= 1'b0;
        wr_status(1'b1, 8'h8C);
        expect_status("status with pin low", 8'h80);
        @(posedge clk) wp_n <= 1'b1;
        fork
            wr_status(1'b1, 8'h84);
            begin
                #2200ns;
                @(posedge clk) wp_n <= 1'b0;
            end
        join
        expect_status("pin taken at select", 8'h84);
        @(posedge clk) wp_n <= 1'b1;
        wr_status(1'b1, 8'h00);
        @(posedge clk) wp_n <= 1'b0;
        wr_status(1'b1, 8'h08);
        expect_status("pin ignored when disabled", 8'h08);
        @(posedge clk) wp_n <= 1'b1;
        wr_status(1'b1, 8'h00);
        $display("test pin done");
    endtask : t_pin

    task automatic t_pause();
        cmd(OP_SET_LATCH);
        mem_frame(OP_MEM_WRITE, 16'h0100, 2, 8'hD0, 3);
        check("paused write", 8'hD0, mem[15'h0100]);
        mem_frame(OP_MEM_READ, 16'h0100, 2, 8'h00, 3);
        check("release in pause", 8'h01, {7'h00, i_host.oe_seen});
        check("read after resume", 8'hD1, rbuf[1]);
        check("release when idle", 8'h01, {7'h00, so_oe_n});
        $display("test pause done");
    endtask : t_pause

    task automatic t_reset();
        wr_status(1'b1, 8'h04);
        cmd(OP_SET_LATCH);
        @(posedge clk) reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        expect_status("status across reset", 8'h04);
        wr_status(1'b1, 8'h00);
        $display("test reset done");
    endtask : t_reset

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        comparisons = 0;
        reset = 1'b1;
        wp_n = 1'b1;
        for (int a = 0; a < 32768; a++) begin
            mem[a] = 8'h00;
        end
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_guard();
        t_wrap();
        t_pin();
        t_pause();
        t_reset();
        summarize();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #2ms;
        errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        summarize();
    end
endmodule : spi_ferro_memory_access_protect_tb
`default_nettype wire
